/* File: logic/counter_array_pkg.sv */
// constants and types shared by the counter array channel mode control block
package counter_array_pkg;

    // ************************************************************
    // bus and value widths
    // ************************************************************
    localparam int DATA_W  = 8;   // special register data width
    localparam int ADDR_W  = 8;   // special register address width
    localparam int COUNT_W = 16;  // shared counter and value width

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [7:0] CH2_MODE_ADDR = 8'hdc;  // channel2_mode_register
    localparam logic [7:0] CH1_LOW_ADDR  = 8'he9;  // channel1_value_low
    localparam logic [7:0] CH1_HIGH_ADDR = 8'hea;  // channel1_value_high
    localparam logic [7:0] CH2_LOW_ADDR  = 8'heb;  // channel 2 value low
    localparam logic [7:0] CH2_HIGH_ADDR = 8'hec;  // channel 2 value high

    // ************************************************************
    // mode register field positions
    // ************************************************************
    localparam int WIDE_MOD_BIT    = 7;  // wide_modulation_select
    localparam int COMP_EN_BIT     = 6;  // comparator_enable
    localparam int RISE_CAP_BIT    = 5;  // rising_capture_enable
    localparam int FALL_CAP_BIT    = 4;  // falling_capture_enable
    localparam int MATCH_EN_BIT    = 3;  // match_enable
    localparam int TOGGLE_EN_BIT   = 2;  // toggle_enable
    localparam int PULSE_EN_BIT    = 1;  // pulse width enable
    localparam int FLAG_IRQ_EN_BIT = 0;  // flag_irq_enable

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  MODE_RESET  = 8'h00;     // mode register
    localparam logic [15:0] VALUE_RESET = 16'h0000;  // compare and reload values
    localparam logic [7:0]  RDATA_RESET = 8'h00;     // read data
    localparam logic [7:0]  UNMAPPED_RD = 8'h00;     // read of an unknown address

    // ************************************************************
    // output modes
    // ************************************************************
    typedef enum logic [2:0] {
        OUT_IDLE   = 3'b000,  // pin holds its level
        OUT_TOGGLE = 3'b001,  // invert on each match
        OUT_PULSE  = 3'b010,  // 8 to 11-bit modulation
        OUT_WIDE   = 3'b011,  // 16-bit modulation
        OUT_FREQ   = 3'b100   // frequency output
    } out_mode_type;

endpackage : counter_array_pkg

/* File: logic/pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 (
    input  wire logic CLK_SYS,   // system clock
    input  wire logic RESET,     // synchronous reset, active high
    input  wire logic PIN_IN,    // asynchronous pin level
    output logic      LEVEL_OUT  // filtered level
);
    logic stage1_ff;  // first stage, read only by stage two
    logic stage2_ff;  // second stage
    logic stage3_ff;  // third stage
    logic level_ff;   // accepted level

    // ************************************************************
    // sampling chain
    // ************************************************************
    // level changes only once stages two and three agree
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
            level_ff  <= 1'b0;
        end else begin
            stage1_ff <= PIN_IN;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            if (stage2_ff == stage3_ff) begin  // agreement reached
                level_ff <= stage3_ff;
            end
        end
    end

    assign LEVEL_OUT = level_ff;
endmodule : pin_sync3

/* File: logic/counter_array_channel_mode_control.sv */
// channel mode control and value registers for the programmable counter array
// Behaviour
// - wide select picks 16-bit, else 8-11-bit modulation
// - bit 6 enables the comparator
// - bit 5 enables rising edge capture
// - bit 4 enables falling edge capture
// - match enable: counter equality sets event flag
// - toggle enable: match inverts the output pin
// - pulse enable drives modulated waveform on pin
// - toggle plus pulse gives frequency output
// - bit 0 masks the event flag interrupt
// - low register holds value least significant byte
// - low address also reaches auto-reload low byte
// - reload select routes low address access
// - low byte write clears comparator enable
// - high byte write sets comparator enable
// - center align bit: edge or center modulation
`timescale 1ns/1ps
module counter_array_channel_mode_control (
    input  wire logic                                  CLK_SYS,            // system clock
    input  wire logic                                  RESET,              // synchronous reset
    input  wire logic [counter_array_pkg::ADDR_W-1:0]  SFR_ADDR,           // register address
    input  wire logic [counter_array_pkg::DATA_W-1:0]  SFR_WDATA,          // write data
    input  wire logic                                  SFR_WE,             // write strobe
    input  wire logic                                  SFR_RE,             // read strobe
    input  wire logic [counter_array_pkg::COUNT_W-1:0] COUNTER,            // shared counter
    input  wire logic                                  COUNTER_TICK,       // counter just stepped
    input  wire logic [1:0]                            PWM_BITS,           // 0..3 gives 8..11 bits
    input  wire logic                                  RELOAD_SELECT,      // reload_select
    input  wire logic                                  CH2_CENTER_ALIGN,   // channel2_center_align
    input  wire logic                                  EVENT_FLAG_CLEAR,   // clear of the event flag
    input  wire logic                                  CH2_CAPTURE_PIN,    // capture input pin
    output logic      [counter_array_pkg::DATA_W-1:0]  SFR_RDATA,          // read data
    output logic                                       CH2_OUTPUT_PIN,     // channel2_output_pin
    output logic                                       CH2_EVENT_FLAG,     // channel2_event_flag
    output logic                                       CH2_IRQ,            // interrupt request
    output logic                                       CH1_COMPARATOR_ENABLE  // channel 1 comparator
);
    import counter_array_pkg::*;

    // ************************************************************
    // helper functions
    // ************************************************************
    // mask of the active counter bits for a modulation width
    function automatic logic [15:0] width_mask(input logic wide, input logic [1:0] bits);
        logic [15:0] m;
        m = 16'h00ff;
        if (wide) begin
            m = 16'hffff;
        end else begin
            m = 16'(({8'h00, 8'hff} << bits) | 16'h00ff);
        end
        return m;
    endfunction : width_mask

    // triangle fold of the masked counter for center alignment
    function automatic logic [15:0] fold_count(input logic [15:0] cnt, input logic [15:0] m);
        logic [15:0] c;
        c = cnt & m;
        if (c > (m >> 1)) begin
            c = 16'(m - c);
        end
        return c;
    endfunction : fold_count

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]   mode_ff;      // channel2_mode_register
    logic [15:0]  ch1_cmp_ff;   // channel 1 compare value
    logic [15:0]  ch1_rld_ff;   // channel 1 auto-reload value
    logic         ch1_comp_ff;  // channel 1 comparator enable
    logic [15:0]  ch2_cmp_ff;   // channel 2 compare value
    logic [15:0]  ch2_rld_ff;   // channel 2 auto-reload value
    logic         flag_ff;      // channel2_event_flag
    logic         irq_ff;       // interrupt request
    logic         pin_ff;       // output pin level
    logic         cap_lvl_ff;   // previous filtered capture level
    logic [7:0]   rdata_ff;     // read data

    // ************************************************************
    // bus decode
    // ************************************************************
    wire wr_mode    = SFR_WE && (SFR_ADDR == CH2_MODE_ADDR);  // mode write
    wire wr_ch1_low = SFR_WE && (SFR_ADDR == CH1_LOW_ADDR);   // ch1 low write
    wire wr_ch1_hi  = SFR_WE && (SFR_ADDR == CH1_HIGH_ADDR);  // ch1 high write
    wire wr_ch2_low = SFR_WE && (SFR_ADDR == CH2_LOW_ADDR);   // ch2 low write
    wire wr_ch2_hi  = SFR_WE && (SFR_ADDR == CH2_HIGH_ADDR);  // ch2 high write

    // ************************************************************
    // mode decode
    // ************************************************************
    wire wide_sel  = mode_ff[WIDE_MOD_BIT];
    wire comp_en   = mode_ff[COMP_EN_BIT];
    wire rise_en   = mode_ff[RISE_CAP_BIT];
    wire fall_en   = mode_ff[FALL_CAP_BIT];
    wire match_en  = mode_ff[MATCH_EN_BIT];
    wire toggle_en = mode_ff[TOGGLE_EN_BIT];
    wire pulse_en  = mode_ff[PULSE_EN_BIT];
    wire irq_en    = mode_ff[FLAG_IRQ_EN_BIT];

    // output mode from the enable bits
    out_mode_type out_mode;
    assign out_mode = (toggle_en && pulse_en) ? OUT_FREQ :
                      pulse_en  ? (wide_sel ? OUT_WIDE : OUT_PULSE) :
                      toggle_en ? OUT_TOGGLE : OUT_IDLE;

    // ************************************************************
    // capture input
    // ************************************************************
    logic cap_lvl;  // filtered capture pin

    pin_sync3 u_cap_sync (
        .CLK_SYS   (CLK_SYS),
        .RESET     (RESET),
        .PIN_IN    (CH2_CAPTURE_PIN),
        .LEVEL_OUT (cap_lvl)
    );

    wire cap_rise = cap_lvl && !cap_lvl_ff;               // rising edge
    wire cap_fall = !cap_lvl && cap_lvl_ff;               // falling edge
    wire capture  = (rise_en && cap_rise) || (fall_en && cap_fall);

    // ************************************************************
    // comparator and modulation
    // ************************************************************
    wire [15:0] mask     = width_mask(wide_sel, PWM_BITS);
    wire        full_hit = (COUNTER == ch2_cmp_ff);                   // 16-bit equality
    wire        freq_hit = (COUNTER[7:0] == ch2_cmp_ff[7:0]);         // low byte equality
    wire        hit      = COUNTER_TICK && comp_en &&
                           ((out_mode == OUT_FREQ) ? freq_hit : full_hit);
    wire        wrap     = COUNTER_TICK && ((COUNTER & mask) == 16'h0000);  // period start
    wire [15:0] cmp_m    = ch2_cmp_ff & mask;                         // masked compare
    wire        edge_lvl = (COUNTER & mask) >= cmp_m;                 // edge-aligned level
    wire        ctr_lvl  = fold_count(COUNTER, mask) >= (cmp_m >> 1); // center-aligned level
    wire        pwm_lvl  = CH2_CENTER_ALIGN ? ctr_lvl : edge_lvl;
    wire        reload   = wrap && pulse_en && !toggle_en && !wide_sel &&
                           (PWM_BITS != 2'b00);

    // next pin level per mode
    logic nxt_pin;
    always_comb begin
        nxt_pin = pin_ff;
        unique case (out_mode)
            OUT_IDLE:   nxt_pin = pin_ff;                        // hold
            OUT_TOGGLE: nxt_pin = hit ? !pin_ff : pin_ff;
            OUT_PULSE:  nxt_pin = comp_en ? pwm_lvl : 1'b0;
            OUT_WIDE:   nxt_pin = comp_en ? pwm_lvl : 1'b0;
            OUT_FREQ:   nxt_pin = hit ? !pin_ff : pin_ff;
            default:    nxt_pin = pin_ff;                        // unused codes
        endcase
    end

    // ************************************************************
    // event flag and interrupt
    // ************************************************************
    wire nxt_flag = (match_en && hit) || capture ? 1'b1 :        // set wins
                    EVENT_FLAG_CLEAR ? 1'b0 : flag_ff;
    wire nxt_irq  = nxt_flag && (wr_mode ? SFR_WDATA[FLAG_IRQ_EN_BIT] : irq_en);

    // ************************************************************
    // mode register next value
    // ************************************************************
    logic [7:0] nxt_mode;
    always_comb begin
        nxt_mode = wr_mode ? SFR_WDATA : mode_ff;
        if (wr_ch2_low) begin
            nxt_mode[COMP_EN_BIT] = 1'b0;
        end
        if (wr_ch2_hi) begin
            nxt_mode[COMP_EN_BIT] = 1'b1;
        end
    end

    // ************************************************************
    // channel 2 value next value
    // ************************************************************
    logic [15:0] nxt_ch2_cmp;
    always_comb begin
        nxt_ch2_cmp = ch2_cmp_ff;
        if (capture) begin
            nxt_ch2_cmp = COUNTER;
        end else if (reload) begin
            nxt_ch2_cmp = ch2_rld_ff;
        end else if (hit && out_mode == OUT_FREQ) begin
            nxt_ch2_cmp[7:0] = 8'(ch2_cmp_ff[7:0] + ch2_cmp_ff[15:8]);     // next edge
        end
        if (wr_ch2_low && !RELOAD_SELECT) begin
            nxt_ch2_cmp[7:0] = SFR_WDATA;
        end
        if (wr_ch2_hi && !RELOAD_SELECT) begin
            nxt_ch2_cmp[15:8] = SFR_WDATA;
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    wire [7:0] rd_ch1_low = RELOAD_SELECT ? ch1_rld_ff[7:0]  : ch1_cmp_ff[7:0];
    wire [7:0] rd_ch1_hi  = RELOAD_SELECT ? ch1_rld_ff[15:8] : ch1_cmp_ff[15:8];
    wire [7:0] rd_ch2_low = RELOAD_SELECT ? ch2_rld_ff[7:0]  : ch2_cmp_ff[7:0];
    wire [7:0] rd_ch2_hi  = RELOAD_SELECT ? ch2_rld_ff[15:8] : ch2_cmp_ff[15:8];
    wire [7:0] rd_mux     = (SFR_ADDR == CH2_MODE_ADDR) ? mode_ff    :
                            (SFR_ADDR == CH1_LOW_ADDR)  ? rd_ch1_low :
                            (SFR_ADDR == CH1_HIGH_ADDR) ? rd_ch1_hi  :
                            (SFR_ADDR == CH2_LOW_ADDR)  ? rd_ch2_low :
                            (SFR_ADDR == CH2_HIGH_ADDR) ? rd_ch2_hi  : UNMAPPED_RD;

    // ************************************************************
    // channel 2 registers
    // ************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            mode_ff    <= MODE_RESET;
            ch2_cmp_ff <= VALUE_RESET;
            flag_ff    <= 1'b0;
            irq_ff     <= 1'b0;
            pin_ff     <= 1'b0;
            cap_lvl_ff <= 1'b0;
        end else begin
            mode_ff    <= nxt_mode;
            ch2_cmp_ff <= nxt_ch2_cmp;
            flag_ff    <= nxt_flag;
            irq_ff     <= nxt_irq;
            pin_ff     <= nxt_pin;
            cap_lvl_ff <= cap_lvl;
        end
    end

    // ************************************************************
    // reload registers and channel 1 registers
    // ************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ch2_rld_ff  <= VALUE_RESET;
            ch1_cmp_ff  <= VALUE_RESET;
            ch1_rld_ff  <= VALUE_RESET;
            ch1_comp_ff <= 1'b0;
        end else begin
            if (wr_ch2_low && RELOAD_SELECT) begin
                ch2_rld_ff[7:0] <= SFR_WDATA;
            end
            if (wr_ch2_hi && RELOAD_SELECT) begin
                ch2_rld_ff[15:8] <= SFR_WDATA;
            end
            if (wr_ch1_low) begin
                if (RELOAD_SELECT) begin
                    ch1_rld_ff[7:0] <= SFR_WDATA;
                end else begin
                    ch1_cmp_ff[7:0] <= SFR_WDATA;
                end
                ch1_comp_ff <= 1'b0;
            end
            if (wr_ch1_hi) begin
                if (RELOAD_SELECT) begin
                    ch1_rld_ff[15:8] <= SFR_WDATA;
                end else begin
                    ch1_cmp_ff[15:8] <= SFR_WDATA;
                end
                ch1_comp_ff <= 1'b1;
            end
        end
    end

    // ************************************************************
    // read data register
    // ************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            rdata_ff <= RDATA_RESET;
        end else if (SFR_RE) begin
            rdata_ff <= rd_mux;
        end
    end

    assign SFR_RDATA             = rdata_ff;
    assign CH2_OUTPUT_PIN        = pin_ff;
    assign CH2_EVENT_FLAG        = flag_ff;
    assign CH2_IRQ               = irq_ff;
    assign CH1_COMPARATOR_ENABLE = ch1_comp_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    // software compare writes win over capture, so those cycles are left out
    sequence s_capture_edge;
        ((rise_en && cap_lvl && !cap_lvl_ff) || (fall_en && !cap_lvl && cap_lvl_ff)) &&
        !((wr_ch2_low || wr_ch2_hi) && !RELOAD_SELECT);
    endsequence

    sequence s_copy_done;
        ch2_cmp_ff == $past(COUNTER) ##0 CH2_EVENT_FLAG;
    endsequence

    a_capture_copy: assert property (s_capture_edge |=> s_copy_done)
        else $error("capture did not copy counter or set flag");

    a_low_clears_comp: assert property (wr_ch2_low && !wr_ch2_hi |=> !mode_ff[COMP_EN_BIT])
        else $error("low byte write left comparator enabled");

    a_high_sets_comp: assert property (wr_ch1_hi |=> CH1_COMPARATOR_ENABLE)
        else $error("high byte write did not set comparator enable");

    a_match_sets_flag: assert property (match_en && hit |=> CH2_EVENT_FLAG)
        else $error("match did not set event flag");

    a_toggle_inverts: assert property (out_mode == OUT_TOGGLE && hit
                                       |=> CH2_OUTPUT_PIN != $past(CH2_OUTPUT_PIN))
        else $error("match did not invert output");

    a_irq_mask_gate: assert property (##1 CH2_IRQ == (CH2_EVENT_FLAG && irq_en))
        else $error("interrupt request disagrees with flag and mask");

    a_reload_route: assert property (wr_ch1_low && RELOAD_SELECT
                                     |=> ch1_rld_ff[7:0] == $past(SFR_WDATA) && $stable(ch1_cmp_ff))
        else $error("reload select did not route low byte write");

    a_low_read_back: assert property (SFR_RE && SFR_ADDR == CH1_LOW_ADDR && !RELOAD_SELECT && !SFR_WE
                                      |=> SFR_RDATA == ch1_cmp_ff[7:0])
        else $error("low byte read returned wrong value");

    a_wide_level: assert property (out_mode == OUT_WIDE && comp_en && !CH2_CENTER_ALIGN
                                   |=> CH2_OUTPUT_PIN == ($past(COUNTER) >= $past(ch2_cmp_ff)))
        else $error("16-bit modulation level wrong");
endmodule : counter_array_channel_mode_control

/* File: verif/pin_partner.sv */
// behavioural model of the circuitry on the channel 2 pins
`timescale 1ns/1ps
module pin_partner (
    input  wire logic       CLK_SYS,      // system clock
    input  wire logic       DRIVE_LEVEL,  // level the source presents
    input  wire logic       OUT_PIN,      // channel output under watch
    output logic            CAPTURE_PIN,  // capture input of the block
    output logic [7:0]      TOGGLES       // output level changes seen
);
    // ************************************************************
    // source and load
    // ************************************************************
    logic last_ff = 1'b0;  // previous output level
    initial begin
        CAPTURE_PIN = 1'b0;
        TOGGLES     = 8'h00;
    end
    // source moves a little after the edge, unrelated to sampling
    always @(posedge CLK_SYS) begin
        CAPTURE_PIN <= #2 DRIVE_LEVEL;
        last_ff     <= OUT_PIN;
        if (OUT_PIN !== last_ff) begin  // count each level change
            TOGGLES <= TOGGLES + 8'h01;
        end
    end
endmodule : pin_partner

/* File: verif/counter_array_channel_mode_control_bench.sv */
// self-checking bench for the channel mode control block
`timescale 1ns/1ps
module counter_array_channel_mode_control_bench;
    import counter_array_pkg::*;
    // ************************************************************
    // stimulus and wiring
    // ************************************************************
    logic        clk_sys, cap_pin, out_pin, flag, irq, ch1_en;
    logic        reset = 1'b1, sfr_we = 1'b0, sfr_re = 1'b0, tick = 1'b0;
    logic        reload_sel = 1'b0, flag_clr = 1'b0, level = 1'b0, center = 1'b0;
    logic [1:0]  pwm_bits = 2'b00;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, toggles, tog0;
    logic [15:0] counter = 16'h0000;
    int          fails = 0, checks_done = 0, cyc = 0;
    counter_array_channel_mode_control i_counter_array_channel_mode_control (
        .CLK_SYS(clk_sys), .RESET(reset), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_WE(sfr_we),
        .SFR_RE(sfr_re), .COUNTER(counter), .COUNTER_TICK(tick), .PWM_BITS(pwm_bits), .RELOAD_SELECT(reload_sel),
        .CH2_CENTER_ALIGN(center), .EVENT_FLAG_CLEAR(flag_clr), .CH2_CAPTURE_PIN(cap_pin), .SFR_RDATA(sfr_rdata),
        .CH2_OUTPUT_PIN(out_pin), .CH2_EVENT_FLAG(flag), .CH2_IRQ(irq), .CH1_COMPARATOR_ENABLE(ch1_en));
    pin_partner i_pin_partner (.CLK_SYS(clk_sys), .DRIVE_LEVEL(level), .OUT_PIN(out_pin),
        .CAPTURE_PIN(cap_pin), .TOGGLES(toggles));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ************************************************************
    // access and check tasks
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_we    <= 1'b1;
        wt(1);
        sfr_we <= 1'b0;
        wt(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr <= a;
        sfr_re   <= 1'b1;
        wt(1);
        sfr_re <= 1'b0;
        #1 chk({8'h00, sfr_rdata}, {8'h00, e});
        wt(1);
    endtask : rd
    task automatic pins(input logic [2:0] e);  // output pin, flag, request
        chk({13'h0000, out_pin, flag, irq}, {13'h0000, e});
    endtask : pins
    task automatic step(input logic [15:0] v);  // one counter step
        counter <= v;
        tick    <= 1'b1;
        wt(1);
        tick <= 1'b0;
        wt(3);
    endtask : step
    task automatic clr();
        flag_clr <= 1'b1;
        wt(1);
        flag_clr <= 1'b0;
        wt(1);
    endtask : clr
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin  // hang guard
        cyc++;
        if (cyc == 2000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        wt(3);
        reset <= 1'b0;
        wt(1);
        rd(CH2_MODE_ADDR, MODE_RESET);
        rd(CH1_LOW_ADDR, 8'h00);
        rd(8'h00, UNMAPPED_RD);
        pins(3'b000);
        wr(CH2_MODE_ADDR, 8'hb5);
        rd(CH2_MODE_ADDR, 8'hb5);
        wr(CH1_LOW_ADDR, 8'h5a);
        chk({15'h0000, ch1_en}, 16'h0000);
        wr(CH1_HIGH_ADDR, 8'h12);
        chk({15'h0000, ch1_en}, 16'h0001);
        wr(CH1_LOW_ADDR, 8'h5a);
        chk({15'h0000, ch1_en}, 16'h0000);
        reload_sel <= 1'b1;
        wr(CH1_LOW_ADDR, 8'h33);
        rd(CH1_LOW_ADDR, 8'h33);
        reload_sel <= 1'b0;
        rd(CH1_LOW_ADDR, 8'h5a);
        // toggle, match flag and request mask
        wr(CH2_MODE_ADDR, 8'h4d);
        wr(CH2_LOW_ADDR, 8'h10);
        rd(CH2_MODE_ADDR, 8'h0d);
        wr(CH2_HIGH_ADDR, 8'h00);
        rd(CH2_MODE_ADDR, 8'h4d);
        tog0 = toggles;
        step(16'h0011);
        pins(3'b000);
        step(16'h0010);
        pins(3'b111);
        wr(CH2_MODE_ADDR, 8'h4c);
        clr();
        step(16'h0010);
        pins(3'b010);
        chk({8'h00, toggles - tog0}, 16'h0002);
        // capture on the enabled edge only
        wr(CH2_MODE_ADDR, 8'h21);
        clr();
        counter <= 16'h1234;
        level   <= 1'b1;
        wt(8);
        pins(3'b011);
        rd(CH2_LOW_ADDR, 8'h34);
        rd(CH2_HIGH_ADDR, 8'h12);
        clr();
        counter <= 16'h5678;
        level   <= 1'b0;
        wt(8);
        pins(3'b000);
        wr(CH2_MODE_ADDR, 8'h10);
        level <= 1'b1;
        wt(8);
        level <= 1'b0;
        wt(8);
        pins(3'b010);
        rd(CH2_LOW_ADDR, 8'h78);
        // modulation widths and frequency output
        wr(CH2_LOW_ADDR, 8'h80);
        wr(CH2_HIGH_ADDR, 8'h00);
        wr(CH2_MODE_ADDR, 8'h42);
        clr();
        step(16'h0090);
        pins(3'b100);
        step(16'h0110);
        pins(3'b000);
        wr(CH2_MODE_ADDR, 8'hc2);
        step(16'h0110);
        pins(3'b100);
        wr(CH2_MODE_ADDR, 8'h46);
        wt(2);
        tog0 = toggles;
        step(16'h0380);
        chk({8'h00, toggles - tog0}, 16'h0001);
        // reload at period start in 9-bit modulation, then center alignment
        reload_sel <= 1'b1;
        wr(CH2_LOW_ADDR, 8'h40);
        wr(CH2_HIGH_ADDR, 8'h01);
        reload_sel <= 1'b0;
        wr(CH2_MODE_ADDR, 8'h42);
        pwm_bits <= 2'b01;
        step(16'h0000);
        step(16'h0100);
        pins(3'b000);
        rd(CH2_LOW_ADDR, 8'h40);
        rd(CH2_HIGH_ADDR, 8'h01);
        pwm_bits <= 2'b00;
        center   <= 1'b1;
        step(16'h0030);
        pins(3'b100);
        center <= 1'b0;
        wt(2);
        pins(3'b000);
        tally_and_finish();
    end
endmodule : counter_array_channel_mode_control_bench
